// file: inc/pfsp_pkg.sv
// Constants for the program flash self-programming controller.
// Assumes one core clock at 25 MHz and a byte-wide register port.
package pfsp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned LONG_OP_TIME_NS = 2_000_000;
  // Longest time, so rounded down
  localparam int unsigned LONG_OP_CYCLES  = LONG_OP_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL    = 12'h0fa6;
  localparam logic [11:0] ADDR_UNLOCK  = 12'h0fa7;
  localparam logic [11:0] ADDR_LATCH   = 12'h0ff5;
  localparam logic [11:0] ADDR_PTR_LOW = 12'h0ff6;
  localparam logic [11:0] ADDR_PTR_HI  = 12'h0ff7;
  localparam logic [11:0] ADDR_PTR_UP  = 12'h0ff8;

  // ---------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------
  localparam int CTL_RD    = 0;
  localparam int CTL_WR    = 1;
  localparam int CTL_WRITE_ENABLE_BIT  = 2;
  localparam int CTL_WRITE_ABORT_FLAG = 3;
  localparam int CTL_FREE  = 4;
  localparam int CTL_SIGNATURE_SPACE_SELECT  = 5;
  localparam int CTL_CONFIG_SPACE_SELECT  = 6;
  localparam int CTL_PROGRAM_SPACE_SELECT = 7;
  localparam logic [7:0] CTL_RESET_VAL = 8'h00;
  // Bits kept across a clear or watchdog reset
  localparam logic [7:0] CTL_KEEP_MASK = 8'hc8;
  localparam logic [7:0] HOLD_RESET_VAL = 8'hff;

  // ---------------------------------------------------------------
  // Unlock keys and pointer layout
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam int PTR_W     = 22;
  localparam int SPACE_BIT = 21;
  localparam int HOLD_N    = 8;
  localparam int HOLD_IDX_W = 3;
  localparam int ROW_LSB   = 12;
  localparam int BLK_LSB   = 3;

  typedef enum logic [1:0] {
    PTR_KEEP     = 2'b00,
    PTR_POST_INC = 2'b01,
    PTR_POST_DEC = 2'b10,
    PTR_PRE_INC  = 2'b11
  } pfsp_ptr_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_ERASE = 4'b0100,
    ST_PROG  = 4'b1000
  } pfsp_state_e;

  typedef enum logic [2:0] {
    UNL_NONE  = 3'b001,
    UNL_KEY1  = 3'b010,
    UNL_ARMED = 3'b100
  } pfsp_unlock_e;

endpackage

// file: rtl/pfsp_core.sv
// Program flash self-programming controller: table latch, byte pointer,
// holding registers and the guarded, self-timed erase / long write path.
// Assumes the core drives all inputs on core_clk and that the flash array
// returns read data combinationally while flash_rd_en is high.

module pfsp_core
  import pfsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = LONG_OP_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        abort_reset,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [11:0] sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        tbl_req,
  input  wire logic        tbl_write,
  input  wire logic [1:0]  tbl_mode,
  input  wire logic        write_done_clr,
  output logic             write_done_irq_flag,
  output logic             core_stall,
  output logic             flash_rd_en,
  output logic      [20:0] flash_rd_addr,
  input  wire logic [15:0] flash_rd_data,
  output logic             flash_erase_go,
  output logic             flash_prog_go,
  output logic             flash_op_abort,
  output logic      [9:0]  flash_row_addr,
  output logic      [18:0] flash_blk_addr,
  output logic      [63:0] flash_prog_data,
  output logic             ee_read_go,
  output logic             ee_write_go
);

  localparam int TMR_W = $clog2(OP_CYCLES + 1);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  pfsp_state_e       state;
  pfsp_state_e       next_state;
  pfsp_unlock_e      unlock_st;
  logic [7:0]        ctrl;
  logic [7:0]        table_byte_latch;
  logic [PTR_W-1:0]  flash_byte_pointer;
  logic [7:0]        hold [HOLD_N];
  logic [63:0]       hold_flat;
  logic [TMR_W-1:0]  timer;
  logic              rd_hi_byte;

  logic              ctrl_wr;
  logic              key_wr;
  logic              tbl_ok;
  logic              wr_set;
  logic              start_erase;
  logic              op_done;
  logic              long_op;
  logic              flash_target;
  logic [PTR_W-1:0]  ptr_inc;
  logic [PTR_W-1:0]  ptr_dec;
  logic [PTR_W-1:0]  ptr_eff;
  logic [PTR_W-1:0]  next_ptr;

  assign ctrl_wr = sfr_wr && (sfr_addr == ADDR_CTRL);
  assign key_wr  = sfr_wr && (sfr_addr == ADDR_UNLOCK);
  assign long_op = (state == ST_ERASE) || (state == ST_PROG);
  assign tbl_ok  = tbl_req && ((state == ST_IDLE) || (state == ST_READ));
  assign op_done = long_op && (timer == '0);

  // Configuration and signature selects override the flash select
  assign flash_target = ctrl[CTL_PROGRAM_SPACE_SELECT] && !ctrl[CTL_CONFIG_SPACE_SELECT]
                        && !ctrl[CTL_SIGNATURE_SPACE_SELECT];

  // Old write-enable and a full key sequence are both required
  assign wr_set = ctrl_wr && sfr_wdata[CTL_WR] && ctrl[CTL_WRITE_ENABLE_BIT]
                  && (unlock_st == UNL_ARMED)
                  && (state == ST_IDLE) && !abort_reset;
  // Erase select may be written together with write-start; only a row
  // erase exists, there is no path to a whole-array erase
  assign start_erase = wr_set && sfr_wdata[CTL_FREE];

  // -----------------------------------------------------------------
  // Pointer arithmetic
  // -----------------------------------------------------------------
  // Carry never reaches the space bit
  assign ptr_inc = {flash_byte_pointer[SPACE_BIT],
                    flash_byte_pointer[SPACE_BIT-1:0] + 21'h00_0001};
  assign ptr_dec = {flash_byte_pointer[SPACE_BIT],
                    flash_byte_pointer[SPACE_BIT-1:0] - 21'h00_0001};

  always_comb begin
    ptr_eff  = flash_byte_pointer;
    next_ptr = flash_byte_pointer;
    case (pfsp_ptr_mode_e'(tbl_mode))
      PTR_KEEP:     next_ptr = flash_byte_pointer;
      PTR_POST_INC: next_ptr = ptr_inc;
      PTR_POST_DEC: next_ptr = ptr_dec;
      PTR_PRE_INC: begin
        ptr_eff  = ptr_inc;
        next_ptr = ptr_inc;
      end
      default:      next_ptr = flash_byte_pointer;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      flash_byte_pointer <= '0;
    end else if (tbl_ok) begin
      flash_byte_pointer <= next_ptr;
    end else if (sfr_wr && sfr_addr == ADDR_PTR_UP) begin
      flash_byte_pointer[21:16] <= sfr_wdata[5:0];
    end else if (sfr_wr && sfr_addr == ADDR_PTR_HI) begin
      flash_byte_pointer[15:8] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == ADDR_PTR_LOW) begin
      flash_byte_pointer[7:0] <= sfr_wdata;
    end
  end

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE, ST_READ: begin
        if (wr_set) begin
          next_state = start_erase ? ST_ERASE : ST_PROG;
        end else if (tbl_ok && !tbl_write) begin
          next_state = ST_READ;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_ERASE, ST_PROG: begin
        if (op_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      state      <= ST_IDLE;
      core_stall <= 1'b0;
    end else begin
      state      <= next_state;
      // Fetches stop for the whole self-timed interval
      core_stall <= (next_state == ST_ERASE)
                    || (next_state == ST_PROG);
    end
  end

  // Same interval for both operations: erase and block write
  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      timer <= '0;
    end else if (wr_set) begin
      timer <= TMR_W'(OP_CYCLES - 1);
    end else if (long_op && timer != '0) begin
      timer <= timer - TMR_W'(1);
    end
  end

  // -----------------------------------------------------------------
  // Unlock sequence
  // -----------------------------------------------------------------
  // Any off-sequence key write or a control write drops the arming
  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      unlock_st <= UNL_NONE;
    end else if (key_wr) begin
      if (sfr_wdata == UNLOCK_KEY1) begin
        unlock_st <= UNL_KEY1;
      end else if (unlock_st == UNL_KEY1 && sfr_wdata == UNLOCK_KEY2) begin
        unlock_st <= UNL_ARMED;
      end else begin
        unlock_st <= UNL_NONE;
      end
    end else if (ctrl_wr) begin
      unlock_st <= UNL_NONE;
    end
  end

  // -----------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= CTL_RESET_VAL;
    end else if (abort_reset) begin
      ctrl <= ctrl & CTL_KEEP_MASK;
      if (long_op) begin
        ctrl[CTL_WRITE_ABORT_FLAG] <= 1'b1;
      end
    end else begin
      if (ctrl_wr) begin
        ctrl[7:2] <= sfr_wdata[7:2];
      end
      // Start bits: software can only raise them
      if (wr_set) begin
        ctrl[CTL_WR] <= 1'b1;
      end else if (op_done) begin
        ctrl[CTL_WR] <= 1'b0;
      end
      if (ctrl_wr && sfr_wdata[CTL_RD] && !ctrl[CTL_RD]
          && !ctrl[CTL_PROGRAM_SPACE_SELECT] && !sfr_wdata[CTL_PROGRAM_SPACE_SELECT]) begin
        ctrl[CTL_RD] <= 1'b1;
      end else begin
        ctrl[CTL_RD] <= 1'b0;
      end
      if (op_done) begin
        ctrl[CTL_WRITE_ABORT_FLAG] <= 1'b0;
        if (state == ST_ERASE) begin
          ctrl[CTL_FREE] <= 1'b0;
        end
      end
    end
  end

  // Completion wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      write_done_irq_flag <= 1'b0;
    end else if (op_done) begin
      write_done_irq_flag <= 1'b1;
    end else if (write_done_clr) begin
      write_done_irq_flag <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Table latch and read path
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      flash_rd_en   <= 1'b0;
      flash_rd_addr <= '0;
      rd_hi_byte    <= 1'b0;
    end else begin
      flash_rd_en <= tbl_ok && !tbl_write && !wr_set;
      if (tbl_ok && !tbl_write) begin
        flash_rd_addr <= ptr_eff[PTR_W-1:1];
        rd_hi_byte    <= ptr_eff[0];
      end
    end
  end

  // A read in flight wins over a software write of the latch
  always_ff @(posedge core_clk) begin
    if (srst || abort_reset) begin
      table_byte_latch <= '0;
    end else if (state == ST_READ) begin
      table_byte_latch <= rd_hi_byte ? flash_rd_data[15:8]
                                     : flash_rd_data[7:0];
    end else if (sfr_wr && sfr_addr == ADDR_LATCH) begin
      table_byte_latch <= sfr_wdata;
    end
  end

  // -----------------------------------------------------------------
  // Holding registers
  // -----------------------------------------------------------------
  for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
    always_ff @(posedge core_clk) begin
      if (srst) begin
        hold[i] <= HOLD_RESET_VAL;
      end else if (tbl_ok && tbl_write
                   && ptr_eff[HOLD_IDX_W-1:0] == HOLD_IDX_W'(i)) begin
        hold[i] <= table_byte_latch;
      end
    end
    assign hold_flat[8*i +: 8] = hold[i];
  end

  // -----------------------------------------------------------------
  // Array strobes
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flash_erase_go  <= 1'b0;
      flash_prog_go   <= 1'b0;
      ee_write_go     <= 1'b0;
      ee_read_go      <= 1'b0;
      flash_op_abort  <= 1'b0;
      flash_row_addr  <= '0;
      flash_blk_addr  <= '0;
      flash_prog_data <= '0;
    end else begin
      flash_erase_go <= start_erase && flash_target;
      // Whole block at once; there is no byte or word program
      flash_prog_go  <= wr_set && !start_erase && flash_target;
      ee_write_go    <= wr_set && !ctrl[CTL_PROGRAM_SPACE_SELECT] && !ctrl[CTL_CONFIG_SPACE_SELECT]
                        && !ctrl[CTL_SIGNATURE_SPACE_SELECT];
      ee_read_go     <= ctrl_wr && sfr_wdata[CTL_RD] && !ctrl[CTL_RD]
                        && !ctrl[CTL_PROGRAM_SPACE_SELECT] && !sfr_wdata[CTL_PROGRAM_SPACE_SELECT];
      flash_op_abort <= abort_reset && long_op;
      if (wr_set) begin
        flash_row_addr  <= flash_byte_pointer[PTR_W-1:ROW_LSB];
        flash_blk_addr  <= flash_byte_pointer[PTR_W-1:BLK_LSB];
        flash_prog_data <= hold_flat;
      end
    end
  end

  // -----------------------------------------------------------------
  // Register read port
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || !sfr_rd) begin
      sfr_rdata <= '0;
    end else begin
      case (sfr_addr)
        ADDR_CTRL:    sfr_rdata <= ctrl;
        ADDR_UNLOCK:  sfr_rdata <= '0;
        ADDR_LATCH:   sfr_rdata <= table_byte_latch;
        ADDR_PTR_UP:  sfr_rdata <= {2'b00, flash_byte_pointer[21:16]};
        ADDR_PTR_HI:  sfr_rdata <= flash_byte_pointer[15:8];
        ADDR_PTR_LOW: sfr_rdata <= flash_byte_pointer[7:0];
        default:      sfr_rdata <= '0;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  logic [TMR_W:0] stall_len;
  always_ff @(posedge core_clk) begin
    if (srst || !core_stall) begin
      stall_len <= '0;
    end else begin
      stall_len <= stall_len + (TMR_W+1)'(1);
    end
  end

  a_stall_busy: assert property (@(posedge core_clk) disable iff (srst)
    core_stall == long_op) else $error("stall does not match operation");

  a_stall_length: assert property (@(posedge core_clk) disable iff (srst)
    $fell(core_stall) && !$past(abort_reset)
      |-> stall_len == (TMR_W+1)'(OP_CYCLES))
    else $error("stall length differs from programming time");

  a_start_guarded: assert property (@(posedge core_clk) disable iff (srst)
    $rose(ctrl[CTL_WR]) |-> $past(ctrl[CTL_WRITE_ENABLE_BIT])
      && $past(unlock_st) == UNL_ARMED)
    else $error("write-start set without enable and keys");

  a_rd_one_cycle: assert property (@(posedge core_clk) disable iff (srst)
    $rose(ctrl[CTL_RD]) |-> !$past(ctrl[CTL_PROGRAM_SPACE_SELECT]) ##1 !ctrl[CTL_RD])
    else $error("read-start misbehaved");

  a_done_flag: assert property (@(posedge core_clk) disable iff (srst)
    op_done && !abort_reset |=> write_done_irq_flag && !ctrl[CTL_WR]
      && !core_stall)
    else $error("completion did not raise done flag");

  a_erase_clears: assert property (@(posedge core_clk) disable iff (srst)
    op_done && state == ST_ERASE && !abort_reset |=> !ctrl[CTL_FREE])
    else $error("erase select not cleared after erase");

  a_unlock_zero: assert property (@(posedge core_clk) disable iff (srst)
    sfr_rd && sfr_addr == ADDR_UNLOCK |=> sfr_rdata == 8'h00)
    else $error("unlock port read non-zero");

  a_abort_error: assert property (@(posedge core_clk) disable iff (srst)
    abort_reset && long_op |=> ctrl[CTL_WRITE_ABORT_FLAG] && !core_stall)
    else $error("interrupted write not flagged");

  a_space_kept: assert property (@(posedge core_clk) disable iff (srst)
    tbl_ok && !abort_reset |=> flash_byte_pointer[SPACE_BIT]
      == $past(flash_byte_pointer[SPACE_BIT]))
    else $error("space bit changed by table op");

  a_hold_write: assert property (@(posedge core_clk) disable iff (srst)
    tbl_ok && tbl_write |=> hold[$past(ptr_eff[2:0])]
      == $past(table_byte_latch))
    else $error("holding register not written");

endmodule

// file: verification/pfsp_flash_model.sv
// Stand-in for the flash array behind pfsp_core.
// Assumes array reads are strobed by flash_rd_en on core_clk.
module pfsp_flash_model (
  input  wire logic        core_clk,
  input  wire logic        flash_rd_en,
  input  wire logic [20:0] flash_rd_addr,
  output logic      [15:0] flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_word = 16'h0000;
  logic [15:0] word;
  // Word depends on every address bit so a wrong address shows up
  assign word = {flash_rd_addr[7:0] ^ 8'h3c,
                 flash_rd_addr[15:8] ^ {3'b000, flash_rd_addr[20:16]}};
  // Deselected: inverse of the last word, so stale data never matches
  assign flash_rd_data = flash_rd_en ? word : ~last_word;
  always @(posedge core_clk) begin
    if (flash_rd_en) begin
      last_word <= word;
    end
  end
endmodule

// file: verification/pfsp_core_test.sv
// Self-checking bench for pfsp_core: table ops, unlock, timed operations.
// Assumes pfsp_flash_model answers reads; the timed op is cut to 12 cycles.
module pfsp_core_test
  import pfsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPC = 12;
  logic core_clk = 1'b0, srst = 1'b1, abort_reset = 1'b0;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, tbl_req = 1'b0, tbl_write = 1'b0;
  logic write_done_clr = 1'b0, ee_seen = 1'b0;
  logic [11:0] sfr_addr = 12'h0000;
  logic [7:0]  sfr_wdata = 8'h00, sfr_rdata;
  logic [1:0]  tbl_mode = 2'b00;
  logic        write_done_irq_flag, core_stall, flash_rd_en, ee_read_go;
  logic        flash_erase_go, flash_prog_go, flash_op_abort, ee_write_go;
  logic [20:0] flash_rd_addr;
  logic [15:0] flash_rd_data;
  logic [9:0]  flash_row_addr;
  logic [18:0] flash_blk_addr;
  logic [63:0] flash_prog_data, pd;
  logic [21:0] ptr, blk, ea;
  int          failures = 0, n_compared = 0, cyc = 0;

  pfsp_core #(.OP_CYCLES(OPC)) uut (
    .core_clk, .srst, .abort_reset, .sfr_wr, .sfr_rd, .sfr_addr,
    .sfr_wdata, .sfr_rdata, .tbl_req, .tbl_write, .tbl_mode,
    .write_done_clr, .write_done_irq_flag, .core_stall, .flash_rd_en,
    .flash_rd_addr, .flash_rd_data, .flash_erase_go, .flash_prog_go,
    .flash_op_abort, .flash_row_addr, .flash_blk_addr, .flash_prog_data,
    .ee_read_go, .ee_write_go
  );
  pfsp_flash_model flash (.core_clk, .flash_rd_en, .flash_rd_addr,
                          .flash_rd_data);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (ee_read_go) ee_seen = 1'b1;
  // Whole run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] fb(logic [21:0] e);
    logic [15:0] w;
    w = {e[8:1] ^ 8'h3c, e[16:9] ^ {3'b000, e[21:17]}};
    return e[0] ? w[15:8] : w[7:0];
  endfunction
  task automatic check(input string what, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rc(input string n, input logic [11:0] a,
                    input logic [7:0] exp);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 check(n, sfr_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic set_ptr(input logic [21:0] p);
    wr(ADDR_PTR_UP, {2'b00, p[21:16]});
    wr(ADDR_PTR_HI, p[15:8]);
    wr(ADDR_PTR_LOW, p[7:0]);
    ptr = p;
  endtask
  task automatic tbl(input logic w, input logic [1:0] m);
    logic [21:0] inc, dec;
    inc = {ptr[21], ptr[20:0] + 21'd1};
    dec = {ptr[21], ptr[20:0] - 21'd1};
    ea = (m == 2'b11) ? inc : ptr;
    tbl_write <= w;
    tbl_mode  <= m;
    tbl_req   <= 1'b1;
    @(posedge core_clk);
    tbl_req <= 1'b0;
    ptr = (m == 2'b00) ? ptr : (m == 2'b10) ? dec : inc;
    #1 check("rd_en", flash_rd_en, !w);
    if (!w) check("rd_addr", flash_rd_addr, ea[21:1]);
    @(posedge core_clk);
    @(posedge core_clk);
  endtask
  task automatic start_op(input logic [7:0] c);
    logic [1:0] go;
    // Array strobes only when program flash is the selected space
    go = (c[7:5] != 3'b100) ? 2'b00 : c[4] ? 2'b10 : 2'b01;
    wr(ADDR_UNLOCK, UNLOCK_KEY1);
    wr(ADDR_UNLOCK, UNLOCK_KEY2);
    sfr_addr  <= ADDR_CTRL;
    sfr_wdata <= c;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1 check("go", {flash_erase_go, flash_prog_go}, go);
    check("ee_write", ee_write_go, c[7:5] == 3'b000);
    if (c[4]) check("row", flash_row_addr, ptr[21:12]);
    else check("block", flash_blk_addr, ptr[21:3]);
    check("stall", core_stall, 1'b1);
  endtask
  task automatic finish_op(input logic [7:0] c);
    int n;
    n = 0;
    while (core_stall === 1'b1 && n < 100) begin
      n++;
      @(posedge core_clk);
      #1;
    end
    check("stall_len", n, OPC);
    check("done_flag", write_done_irq_flag, 1'b1);
    @(posedge core_clk);
    rc("ctrl_done", ADDR_CTRL, c & 8'he5);
    write_done_clr <= 1'b1;
    @(posedge core_clk);
    write_done_clr <= 1'b0;
    #1 check("done_clr", write_done_irq_flag, 1'b0);
    @(posedge core_clk);
  endtask
  task automatic try_start(input logic [7:0] k1, k2);
    wr(ADDR_UNLOCK, k1);
    wr(ADDR_UNLOCK, k2);
    wr(ADDR_CTRL, 8'h86);
    check("stall_refused", core_stall, 1'b0);
    rc("ctrl_refused", ADDR_CTRL, 8'h84);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h5b87));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rc("ctrl_reset", ADDR_CTRL, CTL_RESET_VAL);
    wr(ADDR_UNLOCK, 8'h3c);
    rc("unlock", ADDR_UNLOCK, 8'h00);
    rc("unmapped", 12'h0123, 8'h00);
    $display("test reset done");
    // The first four start at the top of the 21-bit range; the two increment modes wrap
    for (int i = 0; i < 12; i++) begin
      set_ptr(i < 4 ? 22'h3fffff : 22'($urandom));
      tbl(1'b0, 2'(i));
      rc("latch", ADDR_LATCH, fb(ea));
      rc("ptr_up", ADDR_PTR_UP, {2'b00, ptr[21:16]});
      rc("ptr_hi", ADDR_PTR_HI, ptr[15:8]);
      rc("ptr_low", ADDR_PTR_LOW, ptr[7:0]);
    end
    $display("test table read done");
    blk = (22'($urandom) & 22'h1ffff8) | 22'h000008;
    set_ptr(blk - 22'd1);
    for (int i = 0; i < 8; i++) begin
      pd[8*i +: 8] = 8'($urandom);
      wr(ADDR_LATCH, pd[8*i +: 8]);
      tbl(1'b1, 2'b11);
    end
    wr(ADDR_CTRL, 8'h84);
    start_op(8'h86);
    check("prog_data", flash_prog_data, pd);
    finish_op(8'h86);
    $display("test long write done");
    wr(ADDR_CTRL, 8'h80);
    try_start(UNLOCK_KEY1, UNLOCK_KEY2);
    try_start(UNLOCK_KEY2, UNLOCK_KEY1);
    $display("test refusal done");
    start_op(8'h86);
    repeat (3) @(posedge core_clk);
    abort_reset <= 1'b1;
    @(posedge core_clk);
    abort_reset <= 1'b0;
    #1 check("stall_abort", core_stall, 1'b0);
    check("op_abort", flash_op_abort, 1'b1);
    @(posedge core_clk);
    rc("ctrl_abort", ADDR_CTRL, 8'h88);
    set_ptr(22'($urandom));
    wr(ADDR_CTRL, 8'h94);
    start_op(8'h96);
    finish_op(8'h96);
    $display("test abort and erase done");
    wr(ADDR_CTRL, 8'h85);
    rc("ctrl_rd_flash", ADDR_CTRL, 8'h84);
    check("ee_read_none", ee_seen, 1'b0);
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_CTRL, 8'h05);
    // The watcher sets the flag in this same time step
    #1 check("ee_read", ee_seen, 1'b1);
    rc("ctrl_rd_ee", ADDR_CTRL, 8'h04);
    // Data EEPROM selected: timed write with the EEPROM strobe only
    start_op(8'h06);
    finish_op(8'h06);
    $display("test read start done");
    give_verdict();
  end
endmodule
